// ### core/spw_consts.svh
/*
  Constants of the self-programming access block: register offsets, field
  positions, reset values and address-space bounds.
  Assumes it is included by bare name from core/ and sim/ sources.
*/
// Behaviour
// - Hold the CPU idle during a program write; resume when the array ends the write.
// - Program memory writable only with enable bit 7 set and fuse enabled.
// - Fuse disabled forces the self-programming enable bit to zero.
// - Enabled and id select clear: external moves go to code space 0000-FFFFH.
// - Disabled: external moves to extra RAM 0000-0FFFH, or data flash 1000-2FFFH.
// - Code reads go to code space, or id array 0000-01FFH when select set.
// - Enabled with id select set: external moves address the id array.
// - Program writes use page buffer loading followed by a committing write.
`ifndef SPW_CONSTS_SVH
`define SPW_CONSTS_SVH

// ----------------------------------------------------------------
// Register map (index is the printed offset, byte address is 4x)
// ----------------------------------------------------------------
`define SPW_IDX_MEMCTL 10'h096
`define SPW_IDX_PROGCTL 10'h098
`define SPW_IDX_STATUS 10'h099
`define SPW_RST_MEMCTL 8'h00
`define SPW_RST_PROGCTL 8'h00

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define SPW_BIT_SPE 7
`define SPW_BIT_IDSEL 3
`define SPW_BIT_DFMAP 2
`define SPW_MEMCTL_RSVD_MASK 8'hfc
`define SPW_BIT_LOADONLY 0
`define SPW_BIT_ST_BUSY 0
`define SPW_BIT_ST_FUSE 1
`define SPW_BIT_ST_LOADED 2
`define SPW_BIT_ST_BLOCKED 3

// ----------------------------------------------------------------
// Address spaces and page buffer
// ----------------------------------------------------------------
`define SPW_XRAM_TOP 16'h0fff
`define SPW_DFL_BASE 16'h1000
`define SPW_DFL_TOP 16'h2fff
`define SPW_ID_MASK 16'h01ff
`define SPW_PAGE_BYTES 64
`define SPW_PAGE_IDX_W 6

`endif

// ### core/spw_pkg.sv
/*
  Types shared by the self-programming access block.
  Assumes nothing beyond a SystemVerilog compiler.
*/
package spw_pkg;

  // Target space of a CPU data-pointer access
  typedef enum logic [2:0] {
    SPW_SP_XRAM,
    SPW_SP_DFLASH,
    SPW_SP_EXTDATA,
    SPW_SP_CODE,
    SPW_SP_IDARR
  } spw_space_t;

  // Page write sequencer states
  typedef enum logic [1:0] {
    SPW_ST_IDLE,
    SPW_ST_LOADED,
    SPW_ST_BUSY
  } spw_seq_t;

endpackage

// ### core/spw_route.sv
/*
  Combinational steering of data-pointer moves onto an address space.
  Assumes the enable bit it receives is already gated by the fuse.
*/
`timescale 1ns/1ps
`include "spw_consts.svh"

module spw_route (
  // Mode
  input wire logic spe,
  input wire logic id_sel,
  input wire logic df_map,
  // Access
  input wire logic is_xmove,
  input wire logic [15:0] addr,
  // Result
  output spw_pkg::spw_space_t space,
  output logic [15:0] local_addr
);

  // ----------------------------------------------------------------
  // Decode
  // ----------------------------------------------------------------
  wire logic in_xram = addr <= `SPW_XRAM_TOP;
  wire logic in_dfl = (addr >= `SPW_DFL_BASE) && (addr <= `SPW_DFL_TOP);
  wire logic to_id = id_sel && (!is_xmove || spe);
  wire logic to_code = !to_id && (!is_xmove || spe);

  // Space choice; program spaces take priority over data spaces
  always_comb begin
    if (to_id) begin
      space = spw_pkg::SPW_SP_IDARR;
    end else if (to_code) begin
      space = spw_pkg::SPW_SP_CODE;
    end else if (in_xram) begin
      space = spw_pkg::SPW_SP_XRAM;
    end else if (df_map && in_dfl) begin
      space = spw_pkg::SPW_SP_DFLASH;
    end else begin
      space = spw_pkg::SPW_SP_EXTDATA;
    end
  end

  // Address within the chosen space
  always_comb begin
    case (space)
      spw_pkg::SPW_SP_IDARR: local_addr = addr & `SPW_ID_MASK;
      spw_pkg::SPW_SP_DFLASH: local_addr = addr - `SPW_DFL_BASE;
      default: local_addr = addr;
    endcase
  end

endmodule

// ### core/spw_write_seq.sv
/*
  Page write sequencer: buffer loading, commit, and busy wait on the array.
  Assumes done from the array is a one-cycle pulse after start.
*/
`timescale 1ns/1ps
`include "spw_consts.svh"

module spw_write_seq (
  // Clock and reset
  input wire logic clk,
  input wire logic resetn,
  // Control
  input wire logic load,
  input wire logic commit,
  input wire logic abort,
  input wire logic nvm_done,
  // Status
  output logic busy,
  output logic loaded,
  output logic nvm_start
);

  spw_pkg::spw_seq_t state_q;
  spw_pkg::spw_seq_t state_d;

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    state_d = state_q;
    case (state_q)
      spw_pkg::SPW_ST_IDLE: begin
        if (commit) begin
          state_d = spw_pkg::SPW_ST_BUSY;
        end else if (load) begin
          state_d = spw_pkg::SPW_ST_LOADED;
        end
      end
      spw_pkg::SPW_ST_LOADED: begin
        if (commit) begin
          state_d = spw_pkg::SPW_ST_BUSY;
        end else if (abort) begin
          state_d = spw_pkg::SPW_ST_IDLE;
        end
      end
      spw_pkg::SPW_ST_BUSY: begin
        if (nvm_done) begin
          state_d = spw_pkg::SPW_ST_IDLE;
        end
      end
      default: state_d = spw_pkg::SPW_ST_IDLE;
    endcase
  end

  // State register
  always_ff @(posedge clk) begin
    if (!resetn) begin
      state_q <= spw_pkg::SPW_ST_IDLE;
    end else begin
      state_q <= state_d;
    end
  end

  // Outputs
  assign busy = state_q == spw_pkg::SPW_ST_BUSY;
  assign loaded = state_q == spw_pkg::SPW_ST_LOADED;
  assign nvm_start = (state_q != spw_pkg::SPW_ST_BUSY) && (state_d == spw_pkg::SPW_ST_BUSY);

endmodule

// ### core/spw_top.sv
/*
  Self-programming access control: memory control register, address-space
  steering of CPU data-pointer moves, page buffer and CPU idle during writes.
  Assumes an Avalon-MM master for software, a CPU that issues one move per
  request pulse and waits while cpu_idle is high, and a program array that
  reads the page buffer by index and pulses nvm_done when a write ends.
*/
`timescale 1ns/1ps
`include "spw_consts.svh"

module spw_top (
  // Clock and reset
  input wire logic clk,
  input wire logic resetn,
  // Avalon-MM slave
  input wire logic [11:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  // Fuse
  input wire logic spe_fuse_en,
  // CPU data-pointer moves
  input wire logic cpu_req,
  input wire logic cpu_is_xmove,
  input wire logic cpu_we,
  input wire logic [15:0] cpu_addr,
  input wire logic [7:0] cpu_wdata,
  output logic cpu_idle,
  // Routed access toward the memories
  output logic mem_req,
  output logic mem_we,
  output spw_pkg::spw_space_t mem_space,
  output logic [15:0] mem_addr,
  output logic [7:0] mem_wdata,
  // Program array write port
  output logic nvm_start,
  output logic nvm_to_id,
  output logic [15:0] nvm_page_addr,
  input wire logic [`SPW_PAGE_IDX_W-1:0] nvm_buf_idx,
  output logic [7:0] nvm_buf_data,
  input wire logic nvm_done
);

  // ----------------------------------------------------------------
  // Helper functions
  // ----------------------------------------------------------------

  // Byte-lane merge of the low byte of a register write
  function automatic logic [7:0] spw_merge8(input logic [7:0] old_v, input logic [31:0] wdata,
                                           input logic [3:0] be);
    spw_merge8 = be[0] ? wdata[7:0] : old_v;
  endfunction

  // Page base of an address
  function automatic logic [15:0] spw_page_base(input logic [15:0] a);
    spw_page_base = {a[15:`SPW_PAGE_IDX_W], {`SPW_PAGE_IDX_W{1'b0}}};
  endfunction

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  logic ack_q;
  logic [31:0] rdata_q;
  logic [7:0] memctl_q;
  logic [7:0] memctl_d;
  logic [7:0] progctl_q;
  logic [7:0] progctl_d;
  logic blocked_q;
  logic blocked_d;
  logic [15:0] page_q;
  logic id_page_q;
  logic [7:0] page_buf [0:`SPW_PAGE_BYTES-1];
  logic mem_req_q;
  logic mem_we_q;
  spw_pkg::spw_space_t mem_space_q;
  logic [15:0] mem_addr_q;
  logic [7:0] mem_wdata_q;
  logic [7:0] nvm_data_q;
  spw_pkg::spw_space_t route_space;
  logic [15:0] route_addr;
  logic seq_busy;
  logic seq_loaded;
  logic seq_start;

  // ----------------------------------------------------------------
  // Avalon-MM slave decode
  // ----------------------------------------------------------------

  // One wait cycle, then the answer at the edge where waitrequest is low
  wire logic bus_req = avs_read || avs_write;
  wire logic bus_take = bus_req && ack_q;
  wire logic [9:0] bus_idx = avs_address[11:2];
  wire logic sel_memctl = bus_idx == `SPW_IDX_MEMCTL;
  wire logic sel_progctl = bus_idx == `SPW_IDX_PROGCTL;
  wire logic sel_status = bus_idx == `SPW_IDX_STATUS;
  wire logic wr_memctl = avs_write && bus_take && sel_memctl;
  wire logic wr_progctl = avs_write && bus_take && sel_progctl;
  wire logic rd_status_clr = avs_read && bus_take && sel_status;

  // A back-to-back request waits again, since the acknowledge clears after each taken edge
  assign avs_waitrequest = bus_req && !ack_q;
  assign avs_readdata = rdata_q;

  // ----------------------------------------------------------------
  // Effective mode bits
  // ----------------------------------------------------------------
  wire logic spe_on = memctl_q[`SPW_BIT_SPE] && spe_fuse_en;
  wire logic id_sel = memctl_q[`SPW_BIT_IDSEL];
  wire logic df_map = memctl_q[`SPW_BIT_DFMAP];
  wire logic load_only = progctl_q[`SPW_BIT_LOADONLY];

  // Status word shows the block's own state
  wire logic [7:0] status_v = {4'h0, blocked_q, seq_loaded, spe_fuse_en, seq_busy};

  // Read mux; unmapped words read as zero
  wire logic [7:0] rd_byte = sel_memctl ? memctl_q :
                             sel_progctl ? progctl_q :
                             sel_status ? status_v : 8'h00;

  // ----------------------------------------------------------------
  // CPU access classification
  // ----------------------------------------------------------------

  // A move is accepted only while no program write is running
  wire logic cpu_go = cpu_req && !seq_busy;
  wire logic prog_space = (route_space == spw_pkg::SPW_SP_CODE) ||
                          (route_space == spw_pkg::SPW_SP_IDARR);
  // Stores into program space exist only with the enable on
  wire logic prog_store = cpu_go && cpu_is_xmove && cpu_we && spe_on && prog_space;
  // A store that would hit program space with the enable off
  wire logic blocked_store = cpu_go && cpu_we && !spe_on && prog_space;
  // Page loading, then the commit on the store that starts the write
  wire logic buf_load = prog_store;
  wire logic buf_commit = prog_store && !load_only;
  wire logic new_page = prog_store && !seq_loaded;
  wire logic [`SPW_PAGE_IDX_W-1:0] buf_idx = route_addr[`SPW_PAGE_IDX_W-1:0];
  // Losing the enable drops a half-loaded page
  // A fuse drop clears the enable bit as well, so it abandons the page the same way
  wire logic seq_abort = !spe_on;
  // Plain data accesses go straight out
  wire logic pass_through = cpu_go && !prog_store && !blocked_store;

  // ----------------------------------------------------------------
  // Register next values
  // ----------------------------------------------------------------

  // Memory control; enable bit cannot stand without the fuse
  // The fuse test comes last, so a write cannot raise the enable even for one cycle
  always_comb begin
    memctl_d = memctl_q;
    if (wr_memctl) begin
      memctl_d = spw_merge8(memctl_q, avs_writedata, avs_byteenable) & `SPW_MEMCTL_RSVD_MASK;
    end
    if (!spe_fuse_en) begin
      memctl_d[`SPW_BIT_SPE] = 1'b0;
    end
  end

  // Program control write value after the byte-lane merge
  wire logic [7:0] progctl_wr = spw_merge8(progctl_q, avs_writedata, avs_byteenable);

  // Program control; only the load-only bit is kept, the rest reads zero
  always_comb begin
    progctl_d = progctl_q;
    if (wr_progctl) begin
      progctl_d = {7'h00, progctl_wr[`SPW_BIT_LOADONLY]};
    end
  end

  // Blocked-store flag; a new event wins over the read that clears it
  always_comb begin
    blocked_d = blocked_q;
    if (rd_status_clr) begin
      blocked_d = 1'b0;
    end
    if (blocked_store) begin
      blocked_d = 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // Bus handshake and read data
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!resetn) begin
      ack_q <= 1'b0;
      rdata_q <= 32'h0000_0000;
    end else begin
      ack_q <= bus_req && !ack_q;
      rdata_q <= {24'h00_0000, rd_byte};
    end
  end

  // ----------------------------------------------------------------
  // Control registers
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!resetn) begin
      memctl_q <= `SPW_RST_MEMCTL;
      progctl_q <= `SPW_RST_PROGCTL;
      blocked_q <= 1'b0;
    end else begin
      memctl_q <= memctl_d;
      progctl_q <= progctl_d;
      blocked_q <= blocked_d;
    end
  end

  // ----------------------------------------------------------------
  // Address steering
  // ----------------------------------------------------------------
  spw_route u_route (
    .spe(spe_on),
    .id_sel(id_sel),
    .df_map(df_map),
    .is_xmove(cpu_is_xmove),
    .addr(cpu_addr),
    .space(route_space),
    .local_addr(route_addr)
  );

  // ----------------------------------------------------------------
  // Page write sequencer
  // ----------------------------------------------------------------
  spw_write_seq u_seq (
    .clk(clk),
    .resetn(resetn),
    .load(buf_load),
    .commit(buf_commit),
    .abort(seq_abort),
    .nvm_done(nvm_done),
    .busy(seq_busy),
    .loaded(seq_loaded),
    .nvm_start(seq_start)
  );

  // ----------------------------------------------------------------
  // Page buffer and target page
  // ----------------------------------------------------------------

  // Buffer bytes land at their in-page index
  always_ff @(posedge clk) begin
    if (buf_load) begin
      page_buf[buf_idx] <= cpu_wdata;
    end
  end

  // Page address and target array latched by the first byte of a page
  always_ff @(posedge clk) begin
    if (!resetn) begin
      page_q <= 16'h0000;
      id_page_q <= 1'b0;
    end else if (new_page) begin
      page_q <= spw_page_base(route_addr);
      id_page_q <= route_space == spw_pkg::SPW_SP_IDARR;
    end
  end

  // Buffer read-out toward the array, one cycle after the index
  always_ff @(posedge clk) begin
    nvm_data_q <= page_buf[nvm_buf_idx];
  end

  assign nvm_start = seq_start;
  assign nvm_to_id = id_page_q;
  assign nvm_page_addr = page_q;
  assign nvm_buf_data = nvm_data_q;

  // ----------------------------------------------------------------
  // Routed memory access
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!resetn) begin
      mem_req_q <= 1'b0;
      mem_we_q <= 1'b0;
      mem_space_q <= spw_pkg::SPW_SP_XRAM;
      mem_addr_q <= 16'h0000;
      mem_wdata_q <= 8'h00;
    end else begin
      mem_req_q <= pass_through;
      mem_we_q <= pass_through && cpu_we && !prog_space;
      if (pass_through) begin
        mem_space_q <= route_space;
        mem_addr_q <= route_addr;
        mem_wdata_q <= cpu_wdata;
      end
    end
  end

  assign mem_req = mem_req_q;
  assign mem_we = mem_we_q;
  assign mem_space = mem_space_q;
  assign mem_addr = mem_addr_q;
  assign mem_wdata = mem_wdata_q;

  // CPU waits from the committing store until the array is done
  // Moves offered while it waits are dropped, so the CPU must hold its next move
  assign cpu_idle = seq_busy;

endmodule

// ### sim/spw_checker.sv
/*
  Concurrent checks on the ports of spw_top, bound into every instance.
  Assumes one clock domain and a shadow of the mode bits kept from bus writes.
*/
`timescale 1ns/1ps
`include "spw_consts.svh"

module spw_checker (
  // Clock and reset
  input wire logic clk,
  input wire logic resetn,
  // Register bus
  input wire logic [11:0] avs_address,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  input wire logic avs_waitrequest,
  // Fuse and CPU side
  input wire logic spe_fuse_en,
  input wire logic cpu_req,
  input wire logic cpu_is_xmove,
  input wire logic cpu_we,
  input wire logic [15:0] cpu_addr,
  input wire logic cpu_idle,
  // Routed side
  input wire logic mem_req,
  input wire logic mem_we,
  input wire spw_pkg::spw_space_t mem_space,
  input wire logic [15:0] mem_addr,
  input wire logic nvm_start,
  input wire logic nvm_done
);
  logic [7:0] mc_q;
  wire mc_hit = avs_write && !avs_waitrequest && avs_address[11:2] == `SPW_IDX_MEMCTL && avs_byteenable[0];
  wire en = mc_q[7] & spe_fuse_en;
  wire acc = cpu_req && !cpu_idle;

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!resetn);

  // Shadow of the mode bits; a low fuse wins over any write
  always_ff @(posedge clk) begin
    if (!resetn) mc_q <= 8'h00;
    else if (!spe_fuse_en) mc_q <= {1'b0, mc_hit ? avs_writedata[6:0] : mc_q[6:0]};
    else if (mc_hit) mc_q <= avs_writedata[7:0];
  end

  idle_start_a: assert property (nvm_start |=> cpu_idle)
    else $error("cpu not held after a commit");
  idle_end_a: assert property (cpu_idle && nvm_done |=> !cpu_idle)
    else $error("cpu not released after the write ended");
  idle_block_a: assert property (cpu_req && cpu_idle |=> !mem_req)
    else $error("move passed while cpu idle");
  start_gate_a: assert property (nvm_start |-> en && acc && cpu_we)
    else $error("commit without enable");
  fuse_store_a: assert property (acc && cpu_we && cpu_is_xmove && !en |=> mem_req && mem_we && !cpu_idle)
    else $error("disabled store not sent to data space");
  code_store_a: assert property (acc && cpu_we && !cpu_is_xmove && !en |-> !nvm_start ##1 !mem_req)
    else $error("disabled code store had an effect");
  route_xram_a: assert property (acc && cpu_is_xmove && !en && cpu_addr <= `SPW_XRAM_TOP
    |=> mem_req && mem_space == spw_pkg::SPW_SP_XRAM && mem_addr == $past(cpu_addr))
    else $error("extra ram route wrong");
  route_dfl_a: assert property (acc && cpu_is_xmove && !en && mc_q[2] && cpu_addr >= `SPW_DFL_BASE
    && cpu_addr <= `SPW_DFL_TOP |=> mem_space == spw_pkg::SPW_SP_DFLASH
    && mem_addr == $past(cpu_addr) - `SPW_DFL_BASE)
    else $error("data flash route wrong");
  route_code_a: assert property (acc && !cpu_we && !mc_q[3] && (en || !cpu_is_xmove)
    |=> mem_req && mem_space == spw_pkg::SPW_SP_CODE && mem_addr == $past(cpu_addr))
    else $error("code space route wrong");
  route_id_a: assert property (acc && !cpu_we && mc_q[3] && (en || !cpu_is_xmove)
    |=> mem_space == spw_pkg::SPW_SP_IDARR && mem_addr == ($past(cpu_addr) & `SPW_ID_MASK))
    else $error("id array route wrong");
endmodule

bind spw_top spw_checker u_chk (
  .clk(clk), .resetn(resetn), .avs_address(avs_address), .avs_write(avs_write),
  .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable), .avs_waitrequest(avs_waitrequest),
  .spe_fuse_en(spe_fuse_en), .cpu_req(cpu_req), .cpu_is_xmove(cpu_is_xmove), .cpu_we(cpu_we),
  .cpu_addr(cpu_addr), .cpu_idle(cpu_idle), .mem_req(mem_req), .mem_we(mem_we),
  .mem_space(mem_space), .mem_addr(mem_addr), .nvm_start(nvm_start), .nvm_done(nvm_done)
);

// ### sim/spw_nvm_model.sv
/*
  Program array model: on a commit it reads one page buffer byte, then ends
  the write with a one-cycle done pulse after lat cycles (lat of 2 or more).
*/
`timescale 1ns/1ps
`include "spw_consts.svh"

module spw_nvm_model (
  // Clock and reset
  input wire logic clk,
  input wire logic resetn,
  // Control from the bench
  input wire logic [31:0] lat,
  input wire logic [`SPW_PAGE_IDX_W-1:0] pick,
  // Array write port
  input wire logic nvm_start,
  output logic [`SPW_PAGE_IDX_W-1:0] nvm_buf_idx,
  input wire logic [7:0] nvm_buf_data,
  output logic nvm_done,
  output logic [7:0] got
);
  int cnt;

  // Page is read only after a commit; idle index wanders each cycle
  always @(posedge clk) begin
    nvm_done <= 1'b0;
    if (!resetn) begin
      cnt <= 0;
      nvm_buf_idx <= '0;
      got <= 8'h00;
    end else if (nvm_start) begin
      cnt <= 1;
      nvm_buf_idx <= pick;
    end else if (cnt == lat) begin
      got <= nvm_buf_data;
      nvm_done <= 1'b1;
      cnt <= 0;
    end else if (cnt > 0) cnt <= cnt + 1;
    else nvm_buf_idx <= nvm_buf_idx + 1'b1;
  end
endmodule

// ### sim/spw_top_test.sv
/*
  Self-checking bench of spw_top: bus, routing, page writes, fuse.
  Assumes the checker is bound and core/ is on the include path.
*/
`timescale 1ns/1ps
`include "spw_consts.svh"

module spw_top_test;
  logic clk, resetn, avs_read, avs_write, fuse, cpu_req, cpu_xm, cpu_we, avs_waitrequest, xs;
  logic cpu_idle, mem_req, mem_we, nvm_start, nvm_to_id, nvm_done;
  logic [11:0] avs_address;
  logic [31:0] avs_writedata, avs_readdata;
  logic [3:0] avs_be;
  logic [15:0] cpu_addr, mem_addr, nvm_page_addr, base;
  logic [7:0] cpu_wdata, mem_wdata, nvm_buf_data, got, mc, dd;
  logic [5:0] idx, pick;
  spw_pkg::spw_space_t mem_space;
  int lat, n_mismatch, checked, cyc;
  logic [27:0] rq[$];
  logic [31:0] dq[$];

  spw_top DUT (.clk(clk), .resetn(resetn), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_be),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .spe_fuse_en(fuse),
    .cpu_req(cpu_req), .cpu_is_xmove(cpu_xm), .cpu_we(cpu_we), .cpu_addr(cpu_addr),
    .cpu_wdata(cpu_wdata), .cpu_idle(cpu_idle), .mem_req(mem_req), .mem_we(mem_we),
    .mem_space(mem_space), .mem_addr(mem_addr), .mem_wdata(mem_wdata), .nvm_start(nvm_start),
    .nvm_to_id(nvm_to_id), .nvm_page_addr(nvm_page_addr), .nvm_buf_idx(idx),
    .nvm_buf_data(nvm_buf_data), .nvm_done(nvm_done));
  spw_nvm_model u_nvm (.clk(clk), .resetn(resetn), .lat(lat), .pick(pick), .nvm_start(nvm_start),
    .nvm_buf_idx(idx), .nvm_buf_data(nvm_buf_data), .nvm_done(nvm_done), .got(got));

  // ------------------------------------------------------------
  // Compare, report
  // ------------------------------------------------------------
  task automatic chk_val(input logic [31:0] g, input logic [31:0] e);
    checked++;
    if (g !== e) begin
      n_mismatch++;
      $display("mismatch at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  // Write data only matters for stores
  task automatic chk_rt(input logic [27:0] g, input logic [27:0] e);
    if (!e[27]) e[7:0] = g[7:0];
    chk_val({4'h0, g}, {4'h0, e});
  endtask
  task automatic summarize;
    $display("comparisons %0d mismatches %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  // ------------------------------------------------------------
  // Drivers
  // ------------------------------------------------------------
  task automatic bus(input logic w, input logic [11:0] a, input logic [7:0] d, input logic [3:0] be);
    avs_address <= a;
    avs_writedata <= {24'h0, d};
    avs_be <= be;
    if (w) avs_write <= 1'b1;
    else avs_read <= 1'b1;
    do @(posedge clk); while (avs_waitrequest !== 1'b0);
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    @(posedge clk);
  endtask
  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    if (a == 12'h258) mc = d & `SPW_MEMCTL_RSVD_MASK & {fuse, 7'h7f};
    bus(1'b1, a, d, 4'h1);
  endtask
  task automatic rd(input logic [11:0] a, input logic [7:0] e);
    dq.push_back({24'h0, e});
    bus(1'b0, a, 8'h00, 4'hf);
  endtask
  task automatic mv(input logic xm, input logic we, input logic [15:0] a, input logic [7:0] d);
    cpu_req <= 1'b1;
    cpu_xm <= xm;
    cpu_we <= we;
    cpu_addr <= a;
    cpu_wdata <= d;
    @(posedge clk);
  endtask
  task automatic mv_end;
    cpu_req <= 1'b0;
    @(posedge clk);
  endtask
  // Expected routing from the mode bits last written
  task automatic go(input logic xm, input logic we, input logic [15:0] a, input logic [7:0] d);
    logic en;
    spw_pkg::spw_space_t s;
    logic [15:0] la;
    en = mc[7] & fuse;
    la = a;
    if (mc[3] && (en || !xm)) s = spw_pkg::SPW_SP_IDARR;
    else if (en || !xm) s = spw_pkg::SPW_SP_CODE;
    else if (a <= `SPW_XRAM_TOP) s = spw_pkg::SPW_SP_XRAM;
    else if (mc[2] && a <= `SPW_DFL_TOP) s = spw_pkg::SPW_SP_DFLASH;
    else s = spw_pkg::SPW_SP_EXTDATA;
    if (s == spw_pkg::SPW_SP_IDARR) la = a & `SPW_ID_MASK;
    if (s == spw_pkg::SPW_SP_DFLASH) la = a - `SPW_DFL_BASE;
    rq.push_back({we, s, la, d});
    mv(xm, we, a, d);
  endtask

  // Watcher takes the oldest note whenever a result shows
  always @(negedge clk) begin
    if (mem_req === 1'b1 && rq.size() == 0) chk_val(32'h1, 32'h0);
    else if (mem_req === 1'b1) chk_rt({mem_we, mem_space, mem_addr, mem_wdata}, rq.pop_front());
    if (avs_read && avs_waitrequest === 1'b0) chk_val(avs_readdata, dq.pop_front());
  end

  // Clock and hang limit
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc++;
    if (cyc == 5000) begin
      n_mismatch++;
      summarize();
    end
  end

  // ------------------------------------------------------------
  // Tests
  // ------------------------------------------------------------
  initial begin
    {resetn, avs_read, avs_write, cpu_req, cpu_xm, cpu_we} = 6'h00;
    {avs_address, avs_writedata, avs_be, cpu_addr, cpu_wdata, mc} = '0;
    fuse = 1'b1;
    lat = 2;
    pick = 6'h00;
    void'($urandom(32'hd1050132));
    repeat (4) @(posedge clk);
    resetn <= 1'b1;
    rd(12'h258, 8'h00);
    rd(12'h260, 8'h00);
    rd(12'h264, 8'h02);
    wr(12'h100, 8'hff);
    rd(12'h100, 8'h00);
    bus(1'b1, 12'h258, 8'hff, 4'h0);
    rd(12'h258, 8'h00);
    wr(12'h258, 8'h7f);
    rd(12'h258, 8'h7c);
    $display("registers done");
    for (int m = 0; m < 6; m++) begin
      wr(12'h258, {m > 3, 3'h0, m[1:0], 2'h0});
      for (int i = 0; i < 8; i++) begin
        xs = (m > 3) ? 1'b1 : 1'($urandom_range(0, 1));
        go(xs, xs && m < 4 && $urandom_range(0, 1), {2'h0, 2'($urandom), 12'($urandom)},
          8'($urandom));
      end
      mv_end();
    end
    $display("routing done");
    for (int ids = 0; ids < 2; ids++) begin
      wr(12'h260, 8'h01);
      wr(12'h258, {1'b1, 3'h0, ids[0], 3'h0});
      base = ids ? {7'h0, 3'($urandom), 6'h0} : {10'($urandom), 6'h0};
      for (int i = 0; i < 3; i++) mv(1'b1, 1'b1, base + 16'(i), 8'h30 + 8'(i));
      mv_end();
      rd(12'h264, 8'h06);
      wr(12'h260, 8'h00);
      pick = 6'h02;
      lat = ids ? 2 : 9;
      mv(1'b1, 1'b1, base + 16'h3, 8'h55);
      mv(1'b0, 1'b0, 16'h0123, 8'h00);
      mv_end();
      chk_val({31'h0, cpu_idle}, 32'h1);
      for (int k = 0; k < 50 && cpu_idle !== 1'b0; k++) @(posedge clk);
      chk_val({24'h0, got}, 32'h32);
      chk_val({15'h0, nvm_to_id, nvm_page_addr}, {15'h0, ids[0], base});
      go(1'b1, 1'b0, base, 8'h00);
      mv_end();
      rd(12'h264, 8'h02);
    end
    $display("page writes done");
    fuse <= 1'b0;
    @(posedge clk);
    wr(12'h258, 8'h8c);
    rd(12'h258, 8'h0c);
    rd(12'h264, 8'h00);
    dd = 8'($urandom);
    go(1'b1, 1'b1, 16'h0400, dd);
    mv(1'b0, 1'b1, 16'h0010, dd);
    mv_end();
    rd(12'h264, 8'h08);
    rd(12'h264, 8'h00);
    $display("fuse done");
    repeat (4) @(posedge clk);
    chk_val(32'(rq.size() + dq.size()), 32'h0);
    summarize();
  end
endmodule
